// ### verilog/timer_consts.svh
// offsets, field positions, reset values and timing counts of the capture/reload timer
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ----------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------
`define IDX_CONTROL 8'hC8
`define IDX_MODE_CONTROL 8'hC9
`define IDX_RELOAD_LOW 8'hCA
`define IDX_RELOAD_HIGH 8'hCB
`define IDX_COUNT_LOW 8'hCC
`define IDX_COUNT_HIGH 8'hCD

// ----------------------------------------
// control and mode control register fields
// ----------------------------------------
`define BIT_OVERFLOW_FLAG 7
`define BIT_EXTERNAL_FLAG 6
`define BIT_RECEIVE_CLOCK_SELECT 5
`define BIT_TRANSMIT_CLOCK_SELECT 4
`define BIT_TRIGGER_ENABLE 3
`define BIT_RUN_CONTROL 2
`define BIT_COUNTER_SELECT 1
`define BIT_CAPTURE_RELOAD_SELECT 0
`define BIT_DOWN_COUNT_ENABLE 0

// ----------------------------------------
// reset values and the top count
// ----------------------------------------
`define RST_CONTROL 8'h00
`define RST_MODE_CONTROL 1'h0
`define RST_RELOAD 16'h0000
`define RST_COUNT 16'h0000
`define COUNT_TOP 16'hFFFF

// ----------------------------------------
// machine cycle timing in oscillator periods
// ----------------------------------------
`define MC_PERIODS 4'hC
`define MC_LAST 4'hB
`define SAMPLE_PHASE 4'h9
`define UPDATE_PHASE 4'h4

// ----------------------------------------
// bus answers
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### verilog/timer_pkg.sv
// types shared by the capture/reload timer files
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_RELOAD = 2'b01,
    MODE_CAPTURE = 2'b10,
    MODE_BAUD = 2'b11
  } tmr_mode_e;

endpackage

// ### verilog/timing_if.sv
// machine cycle phases and sampled pin events passed to the timer core
`timescale 1ns/1ps
interface timing_if;
  logic mc_tick;
  logic state_tick;
  logic count_fall;
  logic trig_fall;
  logic trig_level;
  logic [3:0] phase;

  modport src (output mc_tick, output state_tick, output count_fall, output trig_fall, output trig_level,
    output phase);
  modport dst (input mc_tick, input state_tick, input count_fall, input trig_fall, input trig_level,
    input phase);
endinterface

// ### verilog/machine_timing.sv
// machine cycle phase counter and pin sampling for the count and trigger inputs
`timescale 1ns/1ps
`include "timer_consts.svh"
module machine_timing (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pins
  input wire logic count_input,
  input wire logic trigger_input,
  // to the core
  timing_if.src tm
);

  // ----------------------------------------
  // phase counter
  // ----------------------------------------
  logic [3:0] phase_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_q <= 4'h0;
    end else if (phase_q == `MC_LAST) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= phase_q + 4'h1;
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_sync_q [2];
  logic [1:0] pin_level_q;
  logic [1:0] samp_q;
  logic [1:0] samp_prev_q;
  logic [1:0] pin_raw;

  assign pin_raw = {trigger_input, count_input};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      // a level counts only once the second and third stage agree
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          pin_sync_q[g] <= 3'h7;
          pin_level_q[g] <= 1'h1;
        end else begin
          pin_sync_q[g] <= {pin_sync_q[g][1:0], pin_raw[g]};
          if (pin_sync_q[g][1] == pin_sync_q[g][2]) begin
            pin_level_q[g] <= pin_sync_q[g][2];
          end
        end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          samp_q[g] <= 1'h1;
          samp_prev_q[g] <= 1'h1;
        end else if (phase_q == `SAMPLE_PHASE) begin
          samp_q[g] <= pin_level_q[g];
          samp_prev_q[g] <= samp_q[g];
        end
      end
    end
  endgenerate

  assign tm.count_fall = (phase_q == `UPDATE_PHASE) && samp_prev_q[0] && !samp_q[0];
  assign tm.trig_fall = (phase_q == `UPDATE_PHASE) && samp_prev_q[1] && !samp_q[1];
  assign tm.trig_level = samp_q[1];
  assign tm.mc_tick = (phase_q == `UPDATE_PHASE);
  assign tm.state_tick = phase_q[0];
  assign tm.phase = phase_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_fall_after_sample: assert property (
    tm.count_fall |-> $past(phase_q, 7) == `SAMPLE_PHASE && samp_prev_q[0] && !samp_q[0])
    else $error("count edge not acted on at the update phase after sampling");

endmodule // machine_timing

// ### verilog/capture_reload_timer.sv
// sixteen bit capture/reload/baud timer with an axi4-lite register port
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "timer_consts.svh"
// Notes on behaviour
// - overflow sets sticky overflow flag
// - no overflow flag while serial selects set
// - enabled trigger edge sets external flag unless down count
// - external flag interrupts unless down count
// - receiver clock from this or other timer
// - transmitter clock from this or other timer
// - trigger edges only when trigger enabled
// - timer runs only while run control set
// - counter select picks cycles or pin edges
// - capture or reload on trigger edges
// - baud mode always reloads on overflow
// - mode decoded from selects and run
// - timer ticks once per machine cycle, every state time in baud mode
// - count pin sampled once per cycle
// - increment visible at next update phase
// - capture mode without trigger is plain timer
// - trigger edge copies count to capture
// - reload mode overflow loads reload pair
// - down count wraps to all ones
// - pins are port bits zero and one
module capture_reload_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // port bit 0 and bit 1 alternate functions
  input wire logic count_input,
  input wire logic trigger_input,
  // serial port and interrupt side
  input wire logic [1:0] serial_mode,
  input wire logic other_timer_overflow,
  input wire logic timer_irq_enable,
  output logic rx_clk_pulse,
  output logic tx_clk_pulse,
  output logic timer_irq,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // timing and pins
  // ----------------------------------------
  timing_if tm ();

  machine_timing u_timing (
    .ref_clk(ref_clk),
    .rst(rst),
    .count_input(count_input),
    .trigger_input(trigger_input),
    .tm(tm)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic down_count_enable_q;
  logic [15:0] rcap_q;
  logic [15:0] cnt_q;

  function automatic logic idx_ok(input logic [11:0] addr);
    idx_ok = (addr[11:10] == 2'h0) && (addr[9:2] >= `IDX_CONTROL) && (addr[9:2] <= `IDX_COUNT_HIGH);
  endfunction

  function automatic timer_pkg::tmr_mode_e decode_mode(input logic run, input logic baud, input logic cap);
    if (!run) begin
      decode_mode = timer_pkg::MODE_OFF;
    end else if (baud) begin
      decode_mode = timer_pkg::MODE_BAUD;
    end else if (cap) begin
      decode_mode = timer_pkg::MODE_CAPTURE;
    end else begin
      decode_mode = timer_pkg::MODE_RELOAD;
    end
  endfunction

  // ----------------------------------------
  // axi4-lite handshake
  // ----------------------------------------
  logic wr_go;
  logic wr_fire;
  logic rd_go;
  logic [7:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_lane;

  // address and data are taken together, one write in flight
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  assign wr_idx = s_axi_awaddr[9:2];
  assign wr_byte = s_axi_wdata[7:0];
  assign wr_lane = wr_fire && s_axi_wstrb[0] && idx_ok(s_axi_awaddr);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'h0;
      s_axi_wready <= 1'h0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (wr_fire) begin
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= idx_ok(s_axi_awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'h1;
        s_axi_rresp <= idx_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        unique case (s_axi_araddr[9:2])
          `IDX_CONTROL: s_axi_rdata <= {24'h0, ctrl_q};
          `IDX_MODE_CONTROL: s_axi_rdata <= {31'h0, down_count_enable_q};
          `IDX_RELOAD_LOW: s_axi_rdata <= {24'h0, rcap_q[7:0]};
          `IDX_RELOAD_HIGH: s_axi_rdata <= {24'h0, rcap_q[15:8]};
          `IDX_COUNT_LOW: s_axi_rdata <= {24'h0, cnt_q[7:0]};
          `IDX_COUNT_HIGH: s_axi_rdata <= {24'h0, cnt_q[15:8]};
          default: s_axi_rdata <= 32'h0;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'h0;
      end
    end
  end

  // ----------------------------------------
  // count events
  // ----------------------------------------
  logic baud;
  logic trig_en;
  logic down_count_enable_mode;
  logic down;
  logic step;
  logic roll_up;
  logic roll_dn;
  logic roll;
  logic trig_ev;
  logic cap_ev;
  logic trig_reload;
  logic cnt_we;
  timer_pkg::tmr_mode_e mode;

  assign baud = ctrl_q[`BIT_RECEIVE_CLOCK_SELECT] || ctrl_q[`BIT_TRANSMIT_CLOCK_SELECT];
  assign trig_en = ctrl_q[`BIT_TRIGGER_ENABLE];
  assign mode = decode_mode(ctrl_q[`BIT_RUN_CONTROL], baud, ctrl_q[`BIT_CAPTURE_RELOAD_SELECT]);
  assign down_count_enable_mode = down_count_enable_q && (mode == timer_pkg::MODE_RELOAD);
  assign down = down_count_enable_mode && !tm.trig_level;
  // cycles or pin edges
  // baud mode with the timer function steps every state time
  assign step = (mode != timer_pkg::MODE_OFF) &&
    (ctrl_q[`BIT_COUNTER_SELECT] ? tm.count_fall : (baud ? tm.state_tick : tm.mc_tick));
  assign roll_up = step && !down && (cnt_q == `COUNT_TOP);
  assign roll_dn = step && down && (cnt_q == rcap_q);
  assign roll = roll_up || roll_dn;
  assign trig_ev = trig_en && tm.trig_fall;
  assign cap_ev = trig_ev && !baud && ctrl_q[`BIT_CAPTURE_RELOAD_SELECT];
  // in up/down mode the trigger steers direction and never reloads
  assign trig_reload = trig_ev && !baud && !ctrl_q[`BIT_CAPTURE_RELOAD_SELECT] && !down_count_enable_q;
  assign cnt_we = wr_lane && ((wr_idx == `IDX_COUNT_LOW) || (wr_idx == `IDX_COUNT_HIGH));

  // ----------------------------------------
  // count register
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= `RST_COUNT;
    end else if (cnt_we) begin
      // software write wins over a step in the same cycle
      if (wr_idx == `IDX_COUNT_LOW) begin
        cnt_q <= {cnt_q[15:8], wr_byte};
      end else begin
        cnt_q <= {wr_byte, cnt_q[7:0]};
      end
    end else if (roll_dn) begin
      cnt_q <= `COUNT_TOP;
    end else if (roll_up) begin
      unique case (mode)
        timer_pkg::MODE_CAPTURE: cnt_q <= 16'h0000;
        default: cnt_q <= rcap_q;
      endcase
    end else if (trig_reload) begin
      cnt_q <= rcap_q;
    end else if (step) begin
      cnt_q <= down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // capture/reload pair and mode control
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rcap_q <= `RST_RELOAD;
    end else if (cap_ev) begin
      rcap_q <= cnt_q;
    end else if (wr_lane && (wr_idx == `IDX_RELOAD_LOW)) begin
      rcap_q <= {rcap_q[15:8], wr_byte};
    end else if (wr_lane && (wr_idx == `IDX_RELOAD_HIGH)) begin
      rcap_q <= {wr_byte, rcap_q[7:0]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      down_count_enable_q <= `RST_MODE_CONTROL;
    end else if (wr_lane && (wr_idx == `IDX_MODE_CONTROL)) begin
      down_count_enable_q <= wr_byte[`BIT_DOWN_COUNT_ENABLE];
    end
  end

  // ----------------------------------------
  // control register and flags
  // ----------------------------------------
  logic ctrl_we;
  logic ovf_set;
  logic ext_set;
  logic ext_toggle;

  assign ctrl_we = wr_lane && (wr_idx == `IDX_CONTROL);
  assign ovf_set = roll && !baud;
  assign ext_set = trig_ev && !down_count_enable_mode;
  // in up/down mode the external flag is a seventeenth count bit
  assign ext_toggle = down_count_enable_mode && roll;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q[5:0] <= 6'(`RST_CONTROL);
    end else if (ctrl_we) begin
      ctrl_q[5:0] <= wr_byte[5:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q[`BIT_OVERFLOW_FLAG] <= 1'h0;
    end else if (ovf_set) begin
      ctrl_q[`BIT_OVERFLOW_FLAG] <= 1'h1;
    end else if (ctrl_we) begin
      ctrl_q[`BIT_OVERFLOW_FLAG] <= wr_byte[`BIT_OVERFLOW_FLAG];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q[`BIT_EXTERNAL_FLAG] <= 1'h0;
    end else if (ext_set) begin
      ctrl_q[`BIT_EXTERNAL_FLAG] <= 1'h1;
    end else if (ext_toggle) begin
      ctrl_q[`BIT_EXTERNAL_FLAG] <= !ctrl_q[`BIT_EXTERNAL_FLAG];
    end else if (ctrl_we) begin
      ctrl_q[`BIT_EXTERNAL_FLAG] <= wr_byte[`BIT_EXTERNAL_FLAG];
    end
  end

  // ----------------------------------------
  // serial clocks and interrupt request
  // ----------------------------------------
  logic ser_13;

  assign ser_13 = serial_mode[0];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_clk_pulse <= 1'h0;
      tx_clk_pulse <= 1'h0;
      timer_irq <= 1'h0;
    end else begin
      rx_clk_pulse <= ser_13 && (ctrl_q[`BIT_RECEIVE_CLOCK_SELECT] ? roll : other_timer_overflow);
      tx_clk_pulse <= ser_13 && (ctrl_q[`BIT_TRANSMIT_CLOCK_SELECT] ? roll : other_timer_overflow);
      // external flag gated by down count
      timer_irq <= timer_irq_enable &&
        (ctrl_q[`BIT_OVERFLOW_FLAG] || (ctrl_q[`BIT_EXTERNAL_FLAG] && !down_count_enable_q));
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_ovf_flag_set: assert property (ovf_set |=> ctrl_q[`BIT_OVERFLOW_FLAG])
    else $error("overflow did not set the overflow flag");
  chk_baud_no_flag: assert property (
    baud && roll && !ctrl_q[`BIT_OVERFLOW_FLAG] && !ctrl_we |=> !ctrl_q[`BIT_OVERFLOW_FLAG])
    else $error("baud mode rollover set the overflow flag");
  chk_ext_flag_set: assert property (trig_ev && !down_count_enable_mode |=> ctrl_q[`BIT_EXTERNAL_FLAG])
    else $error("trigger edge did not set the external flag");
  chk_irq_gate: assert property (
    ##1 (down_count_enable_q && !ctrl_q[`BIT_OVERFLOW_FLAG]) |=> !timer_irq)
    else $error("external flag raised an interrupt in up/down mode");
  chk_tx_select: assert property (
    ser_13 && ctrl_q[`BIT_TRANSMIT_CLOCK_SELECT] && roll |=> tx_clk_pulse)
    else $error("transmit clock missed a timer overflow");
  chk_run_stop: assert property (mode == timer_pkg::MODE_OFF && !cnt_we && !trig_reload |=> $stable(cnt_q))
    else $error("count moved while stopped");
  chk_capture_copy: assert property (cap_ev |=> rcap_q == $past(cnt_q))
    else $error("capture did not copy the count");
  chk_reload_load: assert property (
    roll_up && mode == timer_pkg::MODE_RELOAD && !cnt_we && !cap_ev |=> cnt_q == $past(rcap_q))
    else $error("overflow did not load the reload pair");
  chk_down_wrap: assert property (roll_dn && !cnt_we |=> cnt_q == 16'hFFFF && ctrl_q[`BIT_OVERFLOW_FLAG])
    else $error("underflow did not wrap to all ones");
  chk_set_wins: assert property (ovf_set && ctrl_we && !wr_byte[7] |=> ctrl_q[`BIT_OVERFLOW_FLAG])
    else $error("software clear beat a hardware set");

endmodule // capture_reload_timer

// ### dv/pin_source.sv
// stand-in for the outside source of the count and trigger pins
`timescale 1ns/1ps
module pin_source (
  // clock
  input wire logic ref_clk,
  // port pins, pulled high while idle
  output logic count_input,
  output logic trigger_input
);
  initial begin
    count_input = 1'b1;
    trigger_input = 1'b1;
  end

  // ------------------------------
  // pulse trains
  // ------------------------------
  // each level held past one machine cycle
  // 16 clocks covers the 12-clock cycle plus the input synchroniser
  task automatic pulse(input bit trig, input int n);
    repeat (n) for (int v = 0; v < 2; v++) begin
      if (trig) trigger_input <= v[0];
      else count_input <= v[0];
      repeat (16) @(posedge ref_clk);
    end
  endtask

  // trigger level steers direction in up/down counting
  task automatic level(input bit lvl);
    trigger_input <= lvl;
    repeat (16) @(posedge ref_clk);
  endtask
endmodule // pin_source

// ### dv/test_capture_reload_timer.sv
// self-checking bench for the capture/reload timer
`timescale 1ns/1ps
`include "timer_consts.svh"
module test_capture_reload_timer;
  // ------------------------------
  // signals and model state
  // ------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] smode = 2'h0;
  logic oth = 1'b0, irq_en = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0] ws = 4'hF;
  logic [1:0] bresp, rresp, resp;
  logic awr, wr, bv, arr, rv, rxp, txp, irq, cin, tin;
  int fails = 0, total_checks = 0, seed = 52, cyc = 0, rxn = 0, txn = 0, othn = 0;
  int t0, r0, x0, o0, tmr, oo;
  // model bytes: control, mode, reload low/high, count low/high
  int m[6];

  capture_reload_timer uut (.ref_clk(ref_clk), .rst(rst), .count_input(cin), .trigger_input(tin),
    .serial_mode(smode), .other_timer_overflow(oth), .timer_irq_enable(irq_en), .rx_clk_pulse(rxp),
    .tx_clk_pulse(txp), .timer_irq(irq), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready));
  pin_source src (.ref_clk(ref_clk), .count_input(cin), .trigger_input(tin));

  initial forever #10 ref_clk = ~ref_clk;
  // counted on the falling edge so the main sequence never races it
  always @(negedge ref_clk) begin
    cyc++;
    if (rxp === 1'b1) rxn++;
    if (txp === 1'b1) txn++;
    if (oth === 1'b1) othn++;
  end

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic void step(int n, bit dn = 1'b0);
    int c;
    repeat (n) begin
      c = m[5] * 256 + m[4];
      if (dn ? c == m[3] * 256 + m[2] : c == 65535) begin
        // up rolls to the reload pair, down rolls to all ones
        c = dn ? 65535 : m[3] * 256 + m[2];
        m[0] = m[0] | 'h80;
        if (m[1] == 1) m[0] = m[0] ^ 'h40;
      end else begin
        c = dn ? c - 1 : c + 1;
      end
      m[4] = c % 256;
      m[5] = c / 256;
    end
  endfunction
  task automatic wr_reg(logic [11:0] a, logic [7:0] d);
    @(posedge ref_clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(logic [11:0] a);
    @(posedge ref_clk);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic wrm(int i, logic [7:0] d);
    wr_reg(12'(4 * (`IDX_CONTROL + i)), d);
    m[i] = (i == 1) ? d & 8'h01 : d;
  endtask
  task automatic rd_all();
    for (int i = 0; i < 6; i++) begin
      rd_reg(12'(4 * (`IDX_CONTROL + i)));
      chk("register", {6'h0, `RESP_OKAY, 8'(m[i])}, {6'h0, resp, rd[7:0]});
    end
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd_all();
    rd_reg(12'h000);
    chk("unmapped read", {6'h0, `RESP_SLVERR, 8'h00}, {6'h0, resp, rd[7:0]});
    wr_reg(12'h004, 8'hFF);
    chk("unmapped write", {14'h0, `RESP_SLVERR}, {14'h0, resp});
    // pin counting across an overflow into a random reload value
    wrm(2, 8'($random(seed)));
    wrm(3, 8'($random(seed)));
    wrm(4, 8'hFD);
    wrm(5, 8'hFF);
    wrm(0, 8'h06);
    src.pulse(1'b0, 5);
    step(5);
    repeat (40) @(posedge ref_clk);
    wrm(0, 8'(m[0]) & 8'hC0 | 8'h02);
    rd_all();
    rd_all();
    // stopped timer ignores pin edges, software clears the flag
    wrm(0, 8'h02);
    src.pulse(1'b0, 3);
    repeat (30) @(posedge ref_clk);
    rd_all();
    // capture on trigger edge
    wrm(4, 8'h34);
    wrm(5, 8'h12);
    wrm(0, 8'h0F);
    src.pulse(1'b0, 3);
    step(3);
    src.pulse(1'b1, 1);
    m[2] = m[4];
    m[3] = m[5];
    m[0] = m[0] | 'h40;
    repeat (40) @(posedge ref_clk);
    rd_all();
    irq_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("irq enabled", 16'h1, {15'h0, irq});
    irq_en <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("irq masked", 16'h0, {15'h0, irq});
    wrm(0, 8'h4B);
    rd_all();
    // trigger ignored while disabled
    wrm(0, 8'h07);
    src.pulse(1'b1, 1);
    repeat (40) @(posedge ref_clk);
    rd_all();
    // reload on trigger edge
    wrm(4, 8'h00);
    wrm(0, 8'h0E);
    src.pulse(1'b1, 1);
    m[4] = m[2];
    m[5] = m[3];
    m[0] = m[0] | 'h40;
    repeat (40) @(posedge ref_clk);
    rd_all();
    // up/down counting: trigger low counts down to the reload pair
    wrm(0, 8'h06);
    wrm(1, 8'h01);
    wrm(2, 8'h10);
    wrm(3, 8'h00);
    wrm(4, 8'h12);
    wrm(5, 8'h00);
    src.level(1'b0);
    src.pulse(1'b0, 4);
    step(4, 1'b1);
    repeat (40) @(posedge ref_clk);
    rd_all();
    wrm(0, 8'h42);
    irq_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("irq in up/down", 16'h0, {15'h0, irq});
    irq_en <= 1'b0;
    wrm(1, 8'h00);
    src.level(1'b1);
    // internal machine cycles
    wrm(4, 8'h00);
    wrm(0, 8'h04);
    t0 = cyc;
    repeat (240) @(posedge ref_clk);
    wrm(0, 8'h00);
    t0 = cyc - t0;
    rd_reg(12'(4 * `IDX_COUNT_LOW));
    chk("timer steps", 16'h1, {15'h0, int'(rd[7:0]) >= t0 / 12 - 1 && int'(rd[7:0]) <= t0 / 12 + 1});
    // baud generator, receive then transmit select
    smode <= 2'h1;
    wrm(2, 8'hF0);
    wrm(3, 8'hFF);
    wrm(4, 8'hF0);
    wrm(5, 8'hFF);
    for (int s = 0; s < 2; s++) begin
      wrm(0, s ? 8'h14 : 8'h24);
      t0 = cyc;
      r0 = rxn;
      x0 = txn;
      o0 = othn;
      repeat (400) @(posedge ref_clk) oth <= ($random(seed) & 3) == 0;
      @(posedge ref_clk) oth <= 1'b0;
      wrm(0, s ? 8'h10 : 8'h20);
      t0 = cyc - t0;
      tmr = s ? txn - x0 : rxn - r0;
      oo = s ? rxn - r0 : txn - x0;
      chk("other timer pulses", 16'(othn - o0), 16'(oo));
      chk("baud pulses", 16'h1, {15'h0, tmr >= t0 / 32 - 1 && tmr <= t0 / 32 + 1});
      rd_reg(12'(4 * `IDX_CONTROL));
      chk("control", 16'(m[0]), {8'h0, rd[7:0]});
    end
    // serial mode 0 takes no timer clocks
    smode <= 2'h0;
    r0 = rxn + txn;
    repeat (20) @(posedge ref_clk) oth <= 1'b1;
    @(posedge ref_clk) oth <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("serial mode 0 pulses", 16'h0, 16'(rxn + txn - r0));
    test_done();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    test_done();
  end
endmodule // test_capture_reload_timer
